// ### inc/pse_cmd_defines.svh
// constants for the quad push-button command block
`ifndef PSE_CMD_DEFINES_SVH
`define PSE_CMD_DEFINES_SVH

// command codes of the three write-only registers
`define RESTART_CMD_CODE    8'h18
`define POWER_CMD_CODE      8'h19
`define RESET_CMD_CODE      8'h1a

// field positions in the restart and power registers
`define HI_NIBBLE_LSB       4
`define LO_NIBBLE_LSB       0

// field positions in the reset register
`define CLEAR_ALL_BIT       7
`define RELEASE_IRQ_BIT     6
`define QUAD_RESET_BIT      4
`define CHAN_RESET_LSB      0

// reset and read-back values
`define CMD_REG_RESET       8'h00
`define READ_BACK_VALUE     8'h00

// settling time after a channel turn-off
`define SETTLE_TIME_MS      5
`define CLK_FREQ_KHZ        100000
`define SETTLE_CYCLES       (`SETTLE_TIME_MS * `CLK_FREQ_KHZ)

`endif

// ### inc/pse_cmd_pkg.sv
// types shared by the push-button command block
package pse_cmd_pkg;

    typedef enum logic [1:0] {
        MODE_OFF    = 2'b00,
        MODE_MANUAL = 2'b01,
        MODE_SEMI   = 2'b10,
        MODE_AUTO   = 2'b11
    } op_mode_t;

    typedef enum logic [1:0] {
        CH_IDLE       = 2'b00,
        CH_WAIT_START = 2'b01,
        CH_WAIT_DONE  = 2'b10
    } chan_state_t;

endpackage

// ### src/settle_timer.sv
// countdown that marks a channel's register clearing as still settling
`timescale 1ns/1ps
`include "pse_cmd_defines.svh"

module settle_timer #(
    parameter int CYCLES = `SETTLE_CYCLES
) (
    input  wire logic core_clk,  // core clock
    input  wire logic reset_n,   // async reset, active low
    input  wire logic start,     // one-cycle pulse, restarts the count
    output logic      busy       // high for CYCLES cycles after start
);
    localparam int W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LOAD = W'(CYCLES);

    logic [W-1:0] cnt_ff;
    logic         busy_ff;
    wire  [W-1:0] nxt_cnt;

    assign nxt_cnt = start ? LOAD :
                     (cnt_ff != '0) ? cnt_ff - W'(1) : '0;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_ff  <= '0;
            busy_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            busy_ff <= (nxt_cnt != '0);
        end
    end

    assign busy = busy_ff;

endmodule // settle_timer

// ### src/pse_channel_pushbutton_cmds.sv
// push-button command registers of one quad of four power channels
//
// Operation
// - restart register: high nibble restarts class, low nibble detect
// - power register: high nibble off, low nibble on; no on in off mode
// - off and on for one channel in one write turns it off
// - fault cool-down or disconnect blocks and drops any power-on request
// - manual mode: power-on turns the channel on at once
// - semi-auto: one turn-on attempt; bad result drops it till rewritten
// - semi-auto without both enables runs one full detect and class first
// - semi-auto both enables: request before class start powers after class
// - auto without both enables: request runs one cycle, powers if valid
// - auto with both enables: turn-on tried after every cycle, no request
// - power-off in any mode disables channel and clears its fields
// - clearing touches only the commanded channels
// - clearing may take up to 5 ms to settle
// - reset register bits are self-clearing; writing 0 does nothing
// - clear-all bit clears events, interrupt bits and releases irq line; code pulses clearAllEvents only, not releaseIrqLine
// - release bit frees irq line, events left untouched
// - quad soft reset returns registers to near power-up state
// - quad soft reset keeps the listed registers at prior values
// - quad soft reset acts on this quad's four channels only
// - channel reset bit forces that channel off in any mode
// - restart: manual runs one cycle, semi-auto sets enable bit
// - reading the restart register returns zero
// - restart during cool-down is kept and run when it ends
`timescale 1ns/1ps
`include "pse_cmd_defines.svh"

module pse_channel_pushbutton_cmds
    import pse_cmd_pkg::*;
#(
    parameter int NCH           = 4,
    parameter int SETTLE_CYCLES = `SETTLE_CYCLES
) (
    input  wire logic           core_clk,        // core clock, 100 MHz
    input  wire logic           reset_n,         // async reset, active low
    input  wire logic           wrStrobe,        // one-cycle register write
    input  wire logic [7:0]     wrCmd,           // command code of the write
    input  wire logic [7:0]     wrData,          // data byte of the write
    input  wire logic           rdStrobe,        // one-cycle register read
    input  wire logic [7:0]     rdCmd,           // command code of the read
    output logic      [7:0]     rdData,          // read data byte
    output logic                rdValid,         // read answer pulse
    input  wire logic [1:0]     opMode,          // operating mode of quad
    input  wire logic [NCH-1:0] discoverEnable,  // detect enable state
    input  wire logic [NCH-1:0] classifyEnable,  // class enable state
    input  wire logic [NCH-1:0] coolDown,        // fault cool-down running
    input  wire logic [NCH-1:0] disconnectEvt,   // disconnect event
    input  wire logic [NCH-1:0] classStart,      // class cycle begins, pulse
    input  wire logic [NCH-1:0] classDone,       // class cycle ends, pulse
    input  wire logic [NCH-1:0] classValid,      // class result valid
    input  wire logic [NCH-1:0] allocOk,         // power allocation suffices
    output logic      [NCH-1:0] channelOn,       // turn channel on, pulse
    output logic      [NCH-1:0] channelOff,      // turn off and clear, pulse
    output logic      [NCH-1:0] runDetect,       // single detect cycle, pulse
    output logic      [NCH-1:0] runClassify,     // single class cycle, pulse
    output logic      [NCH-1:0] setDiscoverEn,   // set detect enable, pulse
    output logic      [NCH-1:0] setClassifyEn,   // set class enable, pulse
    output logic      [NCH-1:0] cancelCoolDown,  // abort cool-down, pulse
    output logic      [NCH-1:0] clearSettling,   // clearing still settling
    output logic                clearAllEvents,  // clear events, pulse
    output logic                releaseIrqLine,  // release irq line, pulse
    output logic                quadSoftReset    // reset quad regs, pulse
);

    // ---------------- write decode ----------------
    wire                wrRestart;
    wire                wrPower;
    wire                wrReset;
    wire  [NCH-1:0]     classRestartBits;
    wire  [NCH-1:0]     discoveryRestartBits;
    wire  [NCH-1:0]     offBits;
    wire  [NCH-1:0]     onBits;
    wire  [NCH-1:0]     chanResetBits;
    wire                clearAllBit;
    wire                releaseBit;
    wire                quadResetBit;
    wire  [NCH-1:0]     offReq;
    wire  [NCH-1:0]     onReq;
    wire                modeOff;
    op_mode_t           mode;

    function automatic logic hit(input logic stb, input logic [7:0] cmd,
                                 input logic [7:0] code);
        hit = stb && (cmd == code);
    endfunction

    assign wrRestart = hit(wrStrobe, wrCmd, `RESTART_CMD_CODE);
    assign wrPower   = hit(wrStrobe, wrCmd, `POWER_CMD_CODE);
    assign wrReset   = hit(wrStrobe, wrCmd, `RESET_CMD_CODE);

    assign classRestartBits     = wrRestart ?
        wrData[`HI_NIBBLE_LSB +: NCH] : '0;
    assign discoveryRestartBits = wrRestart ?
        wrData[`LO_NIBBLE_LSB +: NCH] : '0;

    assign offBits = wrPower ? wrData[`HI_NIBBLE_LSB +: NCH] : '0;
    assign onBits  = wrPower ? wrData[`LO_NIBBLE_LSB +: NCH] : '0;

    assign chanResetBits = wrReset ? wrData[`CHAN_RESET_LSB +: NCH] : '0;
    assign clearAllBit   = wrReset && wrData[`CLEAR_ALL_BIT];
    assign releaseBit    = wrReset && wrData[`RELEASE_IRQ_BIT];
    assign quadResetBit  = wrReset && wrData[`QUAD_RESET_BIT];

    assign mode    = op_mode_t'(opMode);
    assign modeOff = (mode == MODE_OFF);

    // channel reset forces off; quad reset hits all four
    assign offReq = offBits | chanResetBits | {NCH{quadResetBit}};
    // off beats on in one write; on ignored in off mode
    assign onReq  = onBits & ~offReq & {NCH{~modeOff}};

    // ---------------- quad-wide pulses ----------------
    logic       clearAll_ff;
    logic       release_ff;
    logic       quadReset_ff;
    logic [7:0] rdData_ff;
    logic       rdValid_ff;
    wire        rdOurs;

    // all three command registers read back as zero
    assign rdOurs = hit(rdStrobe, rdCmd, `RESTART_CMD_CODE) ||
                    hit(rdStrobe, rdCmd, `POWER_CMD_CODE) ||
                    hit(rdStrobe, rdCmd, `RESET_CMD_CODE);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            clearAll_ff  <= 1'b0;
            release_ff   <= 1'b0;
            quadReset_ff <= 1'b0;
            rdData_ff    <= `CMD_REG_RESET;
            rdValid_ff   <= 1'b0;
        end else begin
            // clear every event and interrupt bit
            clearAll_ff  <= clearAllBit;
            release_ff   <= releaseBit;
            // quad register reset; kept regs outside this block
            quadReset_ff <= quadResetBit;
            rdData_ff    <= `READ_BACK_VALUE;
            rdValid_ff   <= rdOurs;
        end
    end

    assign clearAllEvents = clearAll_ff;
    assign releaseIrqLine = release_ff;
    assign quadSoftReset  = quadReset_ff;
    assign rdData         = rdData_ff;
    assign rdValid        = rdValid_ff;

    // ---------------- per-channel control ----------------
    logic [NCH-1:0] on_ff;
    logic [NCH-1:0] off_ff;
    logic [NCH-1:0] runDet_ff;
    logic [NCH-1:0] runCls_ff;
    logic [NCH-1:0] setDet_ff;
    logic [NCH-1:0] setCls_ff;
    logic [NCH-1:0] cancel_ff;

    genvar i;
    generate
        for (i = 0; i < NCH; i++) begin : g_ch
            chan_state_t state_ff;
            chan_state_t nxt_state;
            logic        pendDet_ff;
            logic        pendCls_ff;
            logic        nxt_pendDet;
            logic        nxt_pendCls;
            logic        nxt_on;
            logic        nxt_runDet;
            logic        nxt_runCls;
            logic        nxt_setDet;
            logic        nxt_setCls;
            wire         blocked;
            wire         bothEn;
            wire         goodResult;

            assign blocked    = coolDown[i] | disconnectEvt[i];
            assign bothEn     = discoverEnable[i] & classifyEnable[i];
            // allocation sampled only at class completion
            assign goodResult = classDone[i] & classValid[i] & allocOk[i];

            always_comb begin
                nxt_state   = state_ff;
                nxt_on      = 1'b0;
                nxt_runDet  = 1'b0;
                nxt_runCls  = 1'b0;
                nxt_setDet  = 1'b0;
                nxt_setCls  = 1'b0;
                nxt_pendDet = pendDet_ff | discoveryRestartBits[i];
                nxt_pendCls = pendCls_ff | classRestartBits[i];
                if (offReq[i]) begin
                    // off drops any pending attempt or restart
                    nxt_state   = CH_IDLE;
                    nxt_pendDet = 1'b0;
                    nxt_pendCls = 1'b0;
                end else begin
                    case (state_ff)
                        CH_IDLE: begin
                            if (onReq[i] && !blocked) begin
                                case (mode)
                                    MODE_MANUAL: begin
                                        nxt_on = 1'b1;
                                    end
                                    MODE_SEMI: begin
                                        nxt_runDet = ~bothEn;
                                        nxt_runCls = ~bothEn;
                                        nxt_state  = CH_WAIT_START;
                                    end
                                    MODE_AUTO: begin
                                        if (!bothEn) begin
                                            nxt_runDet = 1'b1;
                                            nxt_runCls = 1'b1;
                                            nxt_state  = CH_WAIT_START;
                                        end
                                    end
                                    default: begin
                                        nxt_state = CH_IDLE;
                                    end
                                endcase
                            end
                            if (mode == MODE_AUTO && bothEn && goodResult &&
                                !blocked) begin
                                nxt_on = 1'b1;
                            end
                        end
                        CH_WAIT_START: begin
                            // fault or change to off mode abandons attempt
                            if (blocked || modeOff) begin
                                nxt_state = CH_IDLE;
                            end else if (classStart[i]) begin
                                nxt_state = CH_WAIT_DONE;
                            end
                        end
                        CH_WAIT_DONE: begin
                            if (blocked || modeOff) begin
                                nxt_state = CH_IDLE;
                            end else if (classDone[i]) begin
                                // one attempt only, bad result drops it
                                nxt_on    = goodResult;
                                nxt_state = CH_IDLE;
                            end
                        end
                        default: begin
                            nxt_state = CH_IDLE;
                        end
                    endcase
                    // restart held until cool-down is over
                    if (!coolDown[i] && (nxt_pendDet || nxt_pendCls)) begin
                        // manual runs a cycle, semi-auto and auto set enable, off does neither
                        if (mode == MODE_MANUAL) begin
                            nxt_runDet = nxt_runDet | nxt_pendDet;
                            nxt_runCls = nxt_runCls | nxt_pendCls;
                        end else if (!modeOff) begin
                            nxt_setDet = nxt_pendDet;
                            nxt_setCls = nxt_pendCls;
                        end
                        nxt_pendDet = 1'b0;
                        nxt_pendCls = 1'b0;
                    end
                end
            end

            always_ff @(posedge core_clk or negedge reset_n) begin
                if (!reset_n) begin
                    state_ff     <= CH_IDLE;
                    pendDet_ff   <= 1'b0;
                    pendCls_ff   <= 1'b0;
                    on_ff[i]     <= 1'b0;
                    off_ff[i]    <= 1'b0;
                    runDet_ff[i] <= 1'b0;
                    runCls_ff[i] <= 1'b0;
                    setDet_ff[i] <= 1'b0;
                    setCls_ff[i] <= 1'b0;
                    cancel_ff[i] <= 1'b0;
                end else begin
                    state_ff     <= nxt_state;
                    pendDet_ff   <= nxt_pendDet;
                    pendCls_ff   <= nxt_pendCls;
                    on_ff[i]     <= nxt_on;
                    off_ff[i]    <= offReq[i];
                    runDet_ff[i] <= nxt_runDet;
                    runCls_ff[i] <= nxt_runCls;
                    setDet_ff[i] <= nxt_setDet;
                    setCls_ff[i] <= nxt_setCls;
                    // channel reset also aborts a running cool-down
                    cancel_ff[i] <= chanResetBits[i] | quadResetBit;
                end
            end

            settle_timer #(
                .CYCLES (SETTLE_CYCLES)
            ) u_settle (
                .core_clk (core_clk),
                .reset_n  (reset_n),
                .start    (offReq[i]),
                .busy     (clearSettling[i])
            );
        end
    endgenerate

    assign channelOn      = on_ff;
    assign channelOff     = off_ff;
    assign runDetect      = runDet_ff;
    assign runClassify    = runCls_ff;
    assign setDiscoverEn  = setDet_ff;
    assign setClassifyEn  = setCls_ff;
    assign cancelCoolDown = cancel_ff;

endmodule // pse_channel_pushbutton_cmds

// ### verification/pse_cmds_chk.sv
// assertion checker for the quad push-button command block
`timescale 1ns/1ps
`include "pse_cmd_defines.svh"

module pse_cmds_chk
    import pse_cmd_pkg::*;
#(
    parameter int NCH = 4
) (
    input wire logic           core_clk,       // core clock
    input wire logic           reset_n,        // async reset, active low
    input wire logic           wrStrobe,       // register write
    input wire logic [7:0]     wrCmd,          // write command code
    input wire logic [7:0]     wrData,         // write data byte
    input wire logic           rdStrobe,       // register read
    input wire logic [7:0]     rdCmd,          // read command code
    input wire logic [7:0]     rdData,         // read data byte
    input wire logic           rdValid,        // read answer
    input wire logic [1:0]     opMode,         // operating mode
    input wire logic [NCH-1:0] coolDown,       // cool-down running
    input wire logic [NCH-1:0] disconnectEvt,  // disconnect event
    input wire logic [NCH-1:0] channelOn,      // turn-on pulse
    input wire logic [NCH-1:0] channelOff,     // turn-off pulse
    input wire logic [NCH-1:0] runDetect,      // detect cycle pulse
    input wire logic [NCH-1:0] setDiscoverEn,  // detect enable pulse
    input wire logic [NCH-1:0] cancelCoolDown, // cool-down abort
    input wire logic           clearAllEvents, // clear events pulse
    input wire logic           releaseIrqLine, // irq release pulse
    input wire logic           quadSoftReset   // quad reset pulse
);
    logic           pwrWr;
    logic           rstWr;
    logic           rstrtWr;
    logic [NCH-1:0] blocked;
    logic [NCH-1:0] rstBits;
    logic [NCH-1:0] offReq;

    assign pwrWr   = wrStrobe && (wrCmd == `POWER_CMD_CODE);
    assign rstWr   = wrStrobe && (wrCmd == `RESET_CMD_CODE);
    assign rstrtWr = wrStrobe && (wrCmd == `RESTART_CMD_CODE);
    assign blocked = coolDown | disconnectEvt;
    // quad reset counts as a channel reset on all four
    assign rstBits = rstWr ? (wrData[3:0] | {NCH{wrData[4]}}) : '0;
    assign offReq  = (pwrWr ? wrData[7:4] : '0) | rstBits;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    read_zero_a: assert property (
        rdStrobe && (rdCmd inside {`RESTART_CMD_CODE, `POWER_CMD_CODE,
        `RESET_CMD_CODE}) |=> rdValid && rdData == `READ_BACK_VALUE)
        else $error("read answer wrong");
    off_exact_a: assert property (
        1 |=> channelOff == $past(offReq))
        else $error("channel off pulses wrong");
    off_wins_a: assert property (
        pwrWr |=> (channelOn & $past(wrData[7:4])) == '0)
        else $error("on beat off in one write");
    off_mode_a: assert property (
        opMode == MODE_OFF |=> channelOn == '0)
        else $error("power on in off mode");
    manual_on_a: assert property (
        pwrWr && opMode == MODE_MANUAL && blocked == '0
        |=> channelOn == $past(wrData[3:0] & ~wrData[7:4]))
        else $error("manual power on wrong");
    fault_block_a: assert property (
        blocked != '0 |=> (channelOn & $past(blocked)) == '0)
        else $error("power on during fault");
    irq_pulses_a: assert property (
        1 |=> {clearAllEvents, releaseIrqLine, quadSoftReset} ==
        $past(rstWr ? {wrData[7], wrData[6], wrData[4]} : 3'h0))
        else $error("reset register pulses wrong");
    cancel_cool_a: assert property (
        1 |=> cancelCoolDown == $past(rstBits))
        else $error("cool-down cancel wrong");
    restart_manual_a: assert property (
        rstrtWr && opMode == MODE_MANUAL && coolDown == '0
        |=> (runDetect & $past(wrData[3:0])) == $past(wrData[3:0]))
        else $error("manual restart missing");
    restart_semi_a: assert property (
        rstrtWr && opMode == MODE_SEMI && coolDown == '0
        |=> (setDiscoverEn & $past(wrData[3:0])) == $past(wrData[3:0]))
        else $error("semi restart missing");
endmodule // pse_cmds_chk

bind pse_channel_pushbutton_cmds pse_cmds_chk #(.NCH(NCH)) u_chk (
    .core_clk, .reset_n, .wrStrobe, .wrCmd, .wrData, .rdStrobe, .rdCmd,
    .rdData, .rdValid, .opMode, .coolDown, .disconnectEvt, .channelOn,
    .channelOff, .runDetect, .setDiscoverEn, .cancelCoolDown,
    .clearAllEvents, .releaseIrqLine, .quadSoftReset
);

// ### verification/disc_engine_model.sv
// model of the per-channel detect and class engine
`timescale 1ns/1ps

module disc_engine_model (
    input  wire logic       core_clk,   // core clock
    input  wire logic       reset_n,    // async reset, active low
    input  wire logic [3:0] trigger,    // start one class cycle
    output logic      [3:0] classStart, // class begins, pulse
    output logic      [3:0] classDone   // class ends, pulse
);
    for (genvar i = 0; i < 4; i++) begin : g_ch
        logic [2:0] cycle_ff;
        // a trigger while busy is dropped, like a running engine
        always_ff @(posedge core_clk or negedge reset_n) begin
            if (!reset_n) begin
                cycle_ff <= 3'h0;
            end else if (trigger[i] && cycle_ff == 3'h0) begin
                cycle_ff <= 3'h6;
            end else if (cycle_ff != 3'h0) begin
                cycle_ff <= cycle_ff - 3'h1;
            end
        end
        assign classStart[i] = (cycle_ff == 3'h4);
        assign classDone[i]  = (cycle_ff == 3'h1);
    end
endmodule // disc_engine_model

// ### verification/testbench.sv
// self-checking bench for the quad push-button command block
`timescale 1ns/1ps
`include "pse_cmd_defines.svh"

module testbench
    import pse_cmd_pkg::*;
;
    localparam int SET = 20;
    logic       core_clk = 1'b0;
    logic       reset_n = 1'b0;
    logic       wrStrobe = 1'b0;
    logic       rdStrobe = 1'b0;
    logic [7:0] wrCmd = 8'h00, wrData = 8'h00, rdCmd = 8'h00, d, rdData;
    logic [1:0] opMode = 2'b01;
    logic [3:0] discoverEnable = 4'h0, classifyEnable = 4'h0, kick = 4'h0;
    logic [3:0] coolDown = 4'h0, disconnectEvt = 4'h0;
    logic [3:0] classValid = 4'hf, allocOk = 4'hf, acc, trig;
    logic       rdValid, clearAllEvents, releaseIrqLine, quadSoftReset;
    logic [3:0] classStart, classDone, channelOn, channelOff, runDetect;
    logic [3:0] runClassify, setDiscoverEn, setClassifyEn;
    logic [3:0] cancelCoolDown, clearSettling;
    wire  [2:0] irqOut = {clearAllEvents, releaseIrqLine, quadSoftReset};
    wire  [7:0] offOut = {channelOff, cancelCoolDown};
    logic [7:0] rv [8] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h05, 8'h00,
                           8'hff, 8'h00};
    int         err_count = 0;
    int         n_checks = 0;

    always #5 core_clk = ~core_clk;
    assign trig = runClassify | kick;

    pse_channel_pushbutton_cmds #(.NCH(4), .SETTLE_CYCLES(SET)) uut (
        .core_clk, .reset_n, .wrStrobe, .wrCmd, .wrData, .rdStrobe, .rdCmd,
        .rdData, .rdValid, .opMode, .discoverEnable, .classifyEnable,
        .coolDown, .disconnectEvt, .classStart, .classDone, .classValid,
        .allocOk, .channelOn, .channelOff, .runDetect, .runClassify,
        .setDiscoverEn, .setClassifyEn, .cancelCoolDown, .clearSettling,
        .clearAllEvents, .releaseIrqLine, .quadSoftReset
    );
    disc_engine_model u_engine (
        .core_clk, .reset_n, .trigger(trig), .classStart, .classDone
    );

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                       input string msg);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s %h not %h", $time, msg, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // one idle edge first keeps strobes from toggling in one step
    task automatic wr(input logic [7:0] c, input logic [7:0] v);
        @(negedge core_clk);
        wrCmd = c;
        wrData = v;
        wrStrobe = 1'b1;
        @(negedge core_clk);
        wrStrobe = 1'b0;
    endtask

    task automatic watch(input logic [3:0] k);
        kick = k;
        acc = 4'h0;
        repeat (12) begin
            @(negedge core_clk);
            kick = 4'h0;
            acc = acc | channelOn;
        end
    endtask

    function automatic logic [3:0] onExp(input logic [1:0] m,
                                         input logic [7:0] v,
                                         input logic [3:0] b);
        return (m == MODE_MANUAL) ? (v[3:0] & ~v[7:4] & ~b) : 4'h0;
    endfunction

    function automatic logic [15:0] rstExp(input logic [7:0] v);
        return {v[7], v[6], v[4], 5'h00, {2{v[3:0] | {4{v[4]}}}}};
    endfunction

    initial begin
        #300us;
        err_count++;
        test_done();
    end

    initial begin
        d = 8'($urandom(32'h3a5deb67));
        repeat (12) @(negedge core_clk);
        reset_n = 1'b1;
        @(negedge core_clk);
        chk({channelOn, channelOff, runDetect, cancelCoolDown},
            16'h0000, "rst");
        for (int i = 0; i < 4; i++) begin
            @(negedge core_clk);
            rdCmd = 8'h18 + 8'(i);
            rdStrobe = 1'b1;
            @(negedge core_clk);
            rdStrobe = 1'b0;
            chk({rdValid, rdData}, {i < 3, 8'h00}, "read");
        end
        for (int i = 0; i < 16; i++) begin
            opMode = (i < 12) ? MODE_MANUAL : MODE_OFF;
            d = (i == 0) ? 8'hff : 8'($urandom);
            coolDown = (i > 6) ? 4'($urandom) : 4'h0;
            disconnectEvt = (i > 9) ? 4'($urandom) : 4'h0;
            wr(`POWER_CMD_CODE, d);
            chk({channelOff, channelOn}, {d[7:4],
                onExp(opMode, d, coolDown | disconnectEvt)}, "power");
        end
        coolDown = 4'h0;
        disconnectEvt = 4'h0;
        opMode = MODE_MANUAL;
        wr(`POWER_CMD_CODE, 8'h10);
        chk(clearSettling[0], 1, "settle start");
        repeat (SET - 1) @(negedge core_clk);
        chk(clearSettling[0], 1, "settle hold");
        @(negedge core_clk);
        chk(clearSettling[0], 0, "settle end");
        for (int m = 0; m < 4; m++) begin
            opMode = 2'(m);
            d = 8'($urandom);
            wr(`RESTART_CMD_CODE, d);
            chk({runClassify, runDetect},
                (m == 1) ? d : 8'h00, "run");
            chk({setClassifyEn, setDiscoverEn},
                (m > 1) ? d : 8'h00, "en");
            repeat (8) @(negedge core_clk);
        end
        opMode = MODE_MANUAL;
        coolDown = 4'h1;
        wr(`RESTART_CMD_CODE, 8'h01);
        chk(runDetect, 0, "held");
        repeat (3) @(negedge core_clk);
        coolDown = 4'h0;
        @(negedge core_clk);
        chk(runDetect, 1, "released");
        rv[7] = 8'($urandom);
        foreach (rv[i]) begin
            wr(`RESET_CMD_CODE, rv[i]);
            chk({irqOut, 5'h00, offOut},
                rstExp(rv[i]), "reset reg");
        end
        opMode = MODE_SEMI;
        // allocation and result ready before the request
        allocOk = 4'hf;
        wr(`POWER_CMD_CODE, 8'h01);
        chk({runClassify[0], runDetect[0]}, 2'b11, "full cycle");
        watch(4'h0);
        chk(acc, 4'h1, "semi on");
        classValid = 4'h0;
        wr(`POWER_CMD_CODE, 8'h02);
        watch(4'h0);
        chk(acc, 0, "invalid");
        classValid = 4'hf;
        watch(4'h2);
        chk(acc, 0, "no retry");
        discoverEnable = 4'hf;
        classifyEnable = 4'hf;
        wr(`POWER_CMD_CODE, 8'h04);
        chk(runClassify, 0, "no run");
        watch(4'h4);
        chk(acc, 4'h4, "semi both");
        opMode = MODE_AUTO;
        watch(4'h8);
        chk(acc, 4'h8, "auto both");
        discoverEnable = 4'h0;
        wr(`POWER_CMD_CODE, 8'h02);
        chk(runClassify, 4'h2, "auto run");
        watch(4'h0);
        chk(acc, 4'h2, "auto on");
        test_done();
    end
endmodule // testbench
